// File: core/ect_defines.vh
// register offsets, field positions and reset values of the event counter/timer
`ifndef ECT_DEFINES_VH
`define ECT_DEFINES_VH
`define ECT_OFF_CTRL      8'h00
`define ECT_OFF_COUNT     8'h04
`define ECT_OFF_PRE_LIM   8'h08
`define ECT_OFF_PRE_CNT   8'h0c
`define ECT_OFF_MATCH_CTL 8'h10
`define ECT_OFF_EXT_CTL   8'h14
`define ECT_OFF_CAP_CTL   8'h18
`define ECT_OFF_CAP_VAL   8'h1c
`define ECT_OFF_MATCH0    8'h20
`define ECT_OFF_MATCH1    8'h24
`define ECT_OFF_MATCH2    8'h28
`define ECT_OFF_MATCH3    8'h2c
`define ECT_OFF_INT_STAT  8'h30
`define ECT_OFF_INT_MASK  8'h34
// control fields
`define ECT_CTRL_EN       0
`define ECT_CTRL_RST      1
`define ECT_CTRL_MODE_LO  2
`define ECT_CTRL_MODE_HI  3
`define ECT_MODE_TIMER    2'b00
`define ECT_MODE_RISE     2'b01
`define ECT_MODE_FALL     2'b10
`define ECT_MODE_BOTH     2'b11
// match control: three bits per match, base 3*i
`define ECT_MCTL_INT      0
`define ECT_MCTL_RESET    1
`define ECT_MCTL_STOP     2
`define ECT_MCTL_STRIDE   3
// external output control: state in 3:0, action pair at 4+2*i
`define ECT_EXT_ACT_BASE  4
`define ECT_ACT_NONE      2'b00
`define ECT_ACT_LOW       2'b01
`define ECT_ACT_HIGH      2'b10
`define ECT_ACT_TOGGLE    2'b11
// capture control
`define ECT_CCTL_RISE     0
`define ECT_CCTL_FALL     1
`define ECT_CCTL_INT      2
`define ECT_CCTL_CLR_RISE 3
`define ECT_CCTL_CLR_FALL 4
// interrupt status: matches in 3:0, capture in 4
`define ECT_STAT_CAP      4
// reset values
`define ECT_RST_CTRL      4'h0
`define ECT_RST_MCTL      12'h000
`define ECT_RST_EXT       12'h000
`define ECT_RST_CCTL      5'h00
`define ECT_RST_STAT      5'h00
// bus answers
`define ECT_RESP_OKAY     2'b00
`define ECT_RESP_SLVERR   2'b10
`endif

// File: core/ect_timer.v
// event counter/timer with prescaler, four matches, one capture, axi4-lite slave
// How it works
// - width parameter: build two 32-bit, two 16-bit
// - prescaler as wide as the counter
// - timer mode counts clocks through prescaler
// - counter mode counts edges of count pin
// - four match registers compared with count
// - continuous match: keep running, optional interrupt
// - stop match halts counter and prescaler
// - reset match zeroes count, keeps counting
// - four match outputs: low, high, toggle, none
// - capture pin edge copies count to register
// - capture may raise interrupt when enabled
// - selected capture edge clears count and prescaler
// - clear on leading, capture on trailing edge
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`include "ect_defines.vh"
module ect_timer #(
	parameter CNT_W  = 32,
	parameter ADDR_W = 8
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              cnt_pin,
	input  wire              cap_pin,
	output reg  [3:0]        match_out,
	output reg               irq
);
	localparam [CNT_W-1:0] ZERO = {CNT_W{1'b0}};

	function [31:0] zext;
		input [CNT_W-1:0] v;
		begin
			zext = 32'h0000_0000;
			zext[CNT_W-1:0] = v;
		end
	endfunction

	// byte strobes to a bit mask; unstrobed lanes keep their old bits
	function [31:0] lane_mask;
		input [3:0] st;
		integer     b;
		begin
			lane_mask = 32'h0000_0000;
			for (b = 0; b < 4; b = b + 1) begin
				if (st[b])
					lane_mask[b*8 +: 8] = 8'hff;
			end
		end
	endfunction

	// pin synchronisers; the third stage only feeds the edge detectors
	reg cnt_s1_q, cnt_s2_q, cnt_s3_q;
	reg cap_s1_q, cap_s2_q, cap_s3_q;

	reg [3:0]       ctrl_q;
	reg [CNT_W-1:0] count_q;
	reg [CNT_W-1:0] pre_lim_q;
	reg [CNT_W-1:0] pre_cnt_q;
	reg [11:0]      mctl_q;
	reg [11:0]      ext_q;
	reg [4:0]       cctl_q;
	reg [CNT_W-1:0] cap_q;
	reg [CNT_W-1:0] match_q [0:3];
	reg [4:0]       stat_q;
	reg [4:0]       mask_q;

	reg              aw_have_q, w_have_q;
	reg [ADDR_W-1:0] awaddr_q;
	reg [31:0]       wdata_q;
	reg [3:0]        wstrb_q;

	wire cnt_rise = cnt_s2_q & ~cnt_s3_q;
	wire cnt_fall = ~cnt_s2_q & cnt_s3_q;
	wire cap_rise = cap_s2_q & ~cap_s3_q;
	wire cap_fall = ~cap_s2_q & cap_s3_q;

	wire [1:0] mode = ctrl_q[`ECT_CTRL_MODE_HI:`ECT_CTRL_MODE_LO];
	reg        src_evt;
	always @* begin
		case (mode)
			`ECT_MODE_TIMER: src_evt = 1'b1;
			`ECT_MODE_RISE:  src_evt = cnt_rise;
			`ECT_MODE_FALL:  src_evt = cnt_fall;
			default:         src_evt = cnt_rise | cnt_fall;
		endcase
	end

	wire run     = ctrl_q[`ECT_CTRL_EN] & ~ctrl_q[`ECT_CTRL_RST];
	wire pre_adv = run & src_evt;
	wire pre_wrp = pre_adv & (pre_cnt_q == pre_lim_q);

	reg [3:0] hit;
	reg [3:0] hit_int;
	reg       hit_rst;
	reg       hit_stop;
	integer   i;
	integer   k;
	always @* begin
		hit_rst  = 1'b0;
		hit_stop = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			hit[i]     = pre_wrp & (count_q == match_q[i]);
			hit_int[i] = hit[i] & mctl_q[i*`ECT_MCTL_STRIDE + `ECT_MCTL_INT];
			hit_rst    = hit_rst | (hit[i] & mctl_q[i*`ECT_MCTL_STRIDE + `ECT_MCTL_RESET]);
			hit_stop   = hit_stop | (hit[i] & mctl_q[i*`ECT_MCTL_STRIDE + `ECT_MCTL_STOP]);
		end
	end

	wire cap_evt = (cctl_q[`ECT_CCTL_RISE] & cap_rise) | (cctl_q[`ECT_CCTL_FALL] & cap_fall);
	wire cap_clr = (cctl_q[`ECT_CCTL_CLR_RISE] & cap_rise) |
	               (cctl_q[`ECT_CCTL_CLR_FALL] & cap_fall);
	wire [4:0] stat_set = {cap_evt & cctl_q[`ECT_CCTL_INT], hit_int};

	wire       wr_en = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire [7:0] wa    = {{(8-ADDR_W+2){1'b0}}, awaddr_q[ADDR_W-1:2]} << 2;
	reg        wr_ok;
	always @* begin
		case (wa)
			`ECT_OFF_CTRL, `ECT_OFF_COUNT, `ECT_OFF_PRE_LIM, `ECT_OFF_PRE_CNT,
			`ECT_OFF_MATCH_CTL, `ECT_OFF_EXT_CTL, `ECT_OFF_CAP_CTL, `ECT_OFF_CAP_VAL,
			`ECT_OFF_MATCH0, `ECT_OFF_MATCH1, `ECT_OFF_MATCH2, `ECT_OFF_MATCH3,
			`ECT_OFF_INT_STAT, `ECT_OFF_INT_MASK: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end
	wire [31:0] wv = wdata_q;
	wire [3:0]  ws = wstrb_q;
	wire [31:0] bm = lane_mask(ws);
	wire [31:0] wn = wv & bm;

	// read decode
	wire [7:0] ra = {{(8-ADDR_W+2){1'b0}}, s_axi_araddr[ADDR_W-1:2]} << 2;
	reg [31:0] rd_d;
	reg [1:0]  rresp_d;
	always @* begin
		rd_d    = 32'h0000_0000;
		rresp_d = `ECT_RESP_OKAY;
		case (ra)
			`ECT_OFF_CTRL:      rd_d[3:0] = ctrl_q;
			`ECT_OFF_COUNT:     rd_d = zext(count_q);
			`ECT_OFF_PRE_LIM:   rd_d = zext(pre_lim_q);
			`ECT_OFF_PRE_CNT:   rd_d = zext(pre_cnt_q);
			`ECT_OFF_MATCH_CTL: rd_d[11:0] = mctl_q;
			`ECT_OFF_EXT_CTL:   rd_d[11:0] = {ext_q[11:4], match_out};
			`ECT_OFF_CAP_CTL:   rd_d[4:0] = cctl_q;
			`ECT_OFF_CAP_VAL:   rd_d = zext(cap_q);
			`ECT_OFF_MATCH0:    rd_d = zext(match_q[0]);
			`ECT_OFF_MATCH1:    rd_d = zext(match_q[1]);
			`ECT_OFF_MATCH2:    rd_d = zext(match_q[2]);
			`ECT_OFF_MATCH3:    rd_d = zext(match_q[3]);
			`ECT_OFF_INT_STAT:  rd_d[4:0] = stat_q;
			`ECT_OFF_INT_MASK:  rd_d[4:0] = mask_q;
			default:            rresp_d = `ECT_RESP_SLVERR;
		endcase
	end

	// bus handshakes
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ECT_RESP_OKAY;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `ECT_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= {ADDR_W{1'b0}};
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
		end else begin
			s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `ECT_RESP_OKAY : `ECT_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_d;
				s_axi_rresp  <= rresp_d;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// timer core; hardware effects come after software writes so they win
	always @(posedge aclk) begin
		if (!aresetn) begin
			{cnt_s1_q, cnt_s2_q, cnt_s3_q} <= 3'b000;
			{cap_s1_q, cap_s2_q, cap_s3_q} <= 3'b000;
			ctrl_q    <= `ECT_RST_CTRL;
			count_q   <= ZERO;
			pre_lim_q <= ZERO;
			pre_cnt_q <= ZERO;
			mctl_q    <= `ECT_RST_MCTL;
			ext_q     <= `ECT_RST_EXT;
			cctl_q    <= `ECT_RST_CCTL;
			cap_q     <= ZERO;
			match_q[0] <= ZERO;
			match_q[1] <= ZERO;
			match_q[2] <= ZERO;
			match_q[3] <= ZERO;
			stat_q    <= `ECT_RST_STAT;
			mask_q    <= `ECT_RST_STAT;
			match_out <= 4'h0;
			irq       <= 1'b0;
		end else begin
			cnt_s1_q <= cnt_pin;
			cnt_s2_q <= cnt_s1_q;
			cnt_s3_q <= cnt_s2_q;
			cap_s1_q <= cap_pin;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
			if (wr_en) begin
				case (wa)
					`ECT_OFF_CTRL:      ctrl_q <= (ctrl_q & ~bm[3:0]) | wn[3:0];
					`ECT_OFF_COUNT:     count_q <= (count_q & ~bm[CNT_W-1:0]) | wn[CNT_W-1:0];
					`ECT_OFF_PRE_LIM:   pre_lim_q <= (pre_lim_q & ~bm[CNT_W-1:0]) | wn[CNT_W-1:0];
					`ECT_OFF_PRE_CNT:   pre_cnt_q <= (pre_cnt_q & ~bm[CNT_W-1:0]) | wn[CNT_W-1:0];
					`ECT_OFF_MATCH_CTL: mctl_q <= (mctl_q & ~bm[11:0]) | wn[11:0];
					`ECT_OFF_EXT_CTL: begin
						ext_q     <= (ext_q & ~bm[11:0]) | wn[11:0];
						match_out <= (match_out & ~bm[3:0]) | wn[3:0];
					end
					`ECT_OFF_CAP_CTL:   cctl_q <= (cctl_q & ~bm[4:0]) | wn[4:0];
					`ECT_OFF_MATCH0:    match_q[0] <= (match_q[0] & ~bm[CNT_W-1:0]) | wn[CNT_W-1:0];
					`ECT_OFF_MATCH1:    match_q[1] <= (match_q[1] & ~bm[CNT_W-1:0]) | wn[CNT_W-1:0];
					`ECT_OFF_MATCH2:    match_q[2] <= (match_q[2] & ~bm[CNT_W-1:0]) | wn[CNT_W-1:0];
					`ECT_OFF_MATCH3:    match_q[3] <= (match_q[3] & ~bm[CNT_W-1:0]) | wn[CNT_W-1:0];
					`ECT_OFF_INT_MASK:  mask_q <= (mask_q & ~bm[4:0]) | wn[4:0];
					default: ;
				endcase
			end
			// narrower counters wrap at their own width
			if (pre_adv)
				pre_cnt_q <= pre_wrp ? ZERO : pre_cnt_q + 1'b1;
			if (pre_wrp) begin
				if (hit_rst)
					count_q <= ZERO;
				else if (!hit_stop)
					count_q <= count_q + 1'b1;
			end
			if (hit_stop) begin
				ctrl_q[`ECT_CTRL_EN] <= 1'b0;
				pre_cnt_q <= ZERO;
			end
			for (k = 0; k < 4; k = k + 1) begin
				if (hit[k]) begin
					case (ext_q[`ECT_EXT_ACT_BASE + 2*k +: 2])
						`ECT_ACT_LOW:    match_out[k] <= 1'b0;
						`ECT_ACT_HIGH:   match_out[k] <= 1'b1;
						`ECT_ACT_TOGGLE: match_out[k] <= ~match_out[k];
						default:         match_out[k] <= match_out[k];
					endcase
				end
			end
			if (cap_evt)
				cap_q <= count_q;
			// software reset holds both counters at zero while set
			if (cap_clr || ctrl_q[`ECT_CTRL_RST]) begin
				count_q   <= ZERO;
				pre_cnt_q <= ZERO;
			end
			// a new event in the clearing cycle stays set
			if (wr_en && wa == `ECT_OFF_INT_STAT)
				stat_q <= (stat_q & ~wn[4:0]) | stat_set;
			else
				stat_q <= stat_q | stat_set;
			irq <= |(stat_q & mask_q);
		end
	end
endmodule // ect_timer

// File: sim/ect_timer_chk.sv
// port-level assertions for the event counter/timer bus slave
`include "ect_defines.vh"
module ect_timer_chk (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awready,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read answer dropped early");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside
		{`ECT_RESP_OKAY, `ECT_RESP_SLVERR}) else $error("bad write code");
	rd_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `ECT_RESP_SLVERR
		|-> s_axi_rdata == 32'h0) else $error("error read not zero");
	cover property (s_axi_bvalid && s_axi_bresp == `ECT_RESP_SLVERR);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (s_axi_arvalid && s_axi_arready);
endmodule // ect_timer_chk

bind ect_timer ect_timer_chk u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// File: sim/ect_pins.sv
// pin-side model driving the count and capture inputs
module ect_pins (
	output logic cnt_pin,
	output logic cap_pin,
	input  logic aclk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cnt_pin = 1'h0;
	initial cap_pin = 1'h0;
	// n pulses, w cycles high then w low, so the 3-flop sync sees each level
	task drive(input logic sel, input int n, input int w);
		repeat (n) begin
			if (sel) cap_pin <= 1'h1;
			else cnt_pin <= 1'h1;
			repeat (w) @(posedge aclk);
			if (sel) cap_pin <= 1'h0;
			else cnt_pin <= 1'h0;
			repeat (w) @(posedge aclk);
		end
	endtask
endmodule // ect_pins

// File: sim/tb.sv
// self-checking bench for the event counter/timer
`include "ect_defines.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'h0, rstn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0;
	logic        rr = 1'h0, awr, wr_r, bv, arr, rvl, cnt_pin, cap_pin, irq;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, seed = 32'hbc37c31e, rv, rd_d, m;
	logic [1:0]  bresp, rresp, rc_r;
	logic [3:0]  mo;
	int          failures = 0, n_checks = 0;
	always #12.5 aclk = ~aclk;
	ect_timer #(.CNT_W(16)) DUT (.aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr),
		.cnt_pin(cnt_pin), .cap_pin(cap_pin), .match_out(mo), .irq(irq));
	ect_pins P (.aclk(aclk), .cnt_pin(cnt_pin), .cap_pin(cap_pin));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [31:0] resp(input logic [7:0] a);
		return (a > `ECT_OFF_INT_MASK) ? 32'(`ECT_RESP_SLVERR) : 32'(`ECT_RESP_OKAY);
	endfunction
	task stop_test;
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task tmo;
		failures++;
		stop_test();
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		{awa, wd, awv, wv, br} <= {a, d, 3'h7};
		for (int i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (awr) awv <= 1'h0;
			if (wr_r) wv <= 1'h0;
			if (bv) begin
				br <= 1'h0;
				chk(32'(bresp), resp(a));
				@(posedge aclk);
				return;
			end
		end
		tmo();
	endtask
	task rd(input logic [7:0] a);
		{ara, arv, rr} <= {a, 2'h3};
		for (int i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (arr) arv <= 1'h0;
			if (rvl) begin
				rr <= 1'h0;
				{rv, rc_r} = {rd_d, rresp};
				chk(32'(rc_r), resp(a));
				@(posedge aclk);
				return;
			end
		end
		tmo();
	endtask
	task rc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp);
	endtask
	task wirq;
		for (int i = 0; i < 3000; i++) begin
			if (irq === 1'h1) return;
			@(posedge aclk);
		end
		tmo();
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		rstn <= 1'h1;
		@(posedge aclk);
		rc(`ECT_OFF_CTRL, 32'h0);
		wr(`ECT_OFF_COUNT, 32'h12345);
		rc(`ECT_OFF_COUNT, 32'h2345);
		wr(`ECT_OFF_PRE_LIM, 32'hfffff);
		rc(`ECT_OFF_PRE_LIM, 32'hffff);
		wr(8'h40, 32'h1);
		rc(8'h40, 32'h0);
		// match 2 left masked (mask bit 2 clear) to prove masking
		wr(`ECT_OFF_INT_MASK, 32'h13);
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			m = 32'(seed[3:0]) + 32'h3;
			wr(`ECT_OFF_COUNT, 32'h0);
			wr(`ECT_OFF_PRE_LIM, 32'(seed[5:4]));
			wr(`ECT_OFF_MATCH0, m);
			wr(`ECT_OFF_MATCH_CTL, 32'h5);
			wr(`ECT_OFF_EXT_CTL, 32'h30);
			wr(`ECT_OFF_CTRL, 32'h1);
			wirq();
			chk(32'(mo), 32'h1);
			rc(`ECT_OFF_COUNT, m);
			rc(`ECT_OFF_PRE_CNT, 32'h0);
			rc(`ECT_OFF_CTRL, 32'h0);
			rc(`ECT_OFF_INT_STAT, 32'h1);
			wr(`ECT_OFF_INT_STAT, 32'h1);
			repeat (2) @(posedge aclk);
			chk(32'(irq), 32'h0);
		end
		wr(`ECT_OFF_MATCH1, 32'ha);
		wr(`ECT_OFF_MATCH2, 32'h4);
		wr(`ECT_OFF_COUNT, 32'h0);
		wr(`ECT_OFF_PRE_LIM, 32'h0);
		wr(`ECT_OFF_MATCH_CTL, 32'h58);
		wr(`ECT_OFF_EXT_CTL, 32'h180);
		wr(`ECT_OFF_CTRL, 32'h1);
		wirq();
		chk(32'(mo), 32'h2);
		rc(`ECT_OFF_CTRL, 32'h1);
		rc(`ECT_OFF_INT_STAT, 32'h6);
		rd(`ECT_OFF_COUNT);
		chk(32'(rv <= 32'ha), 32'h1);
		wr(`ECT_OFF_CTRL, 32'h0);
		wr(`ECT_OFF_MATCH_CTL, 32'h0);
		wr(`ECT_OFF_INT_STAT, 32'h1f);
		seed = lfsr(seed);
		m = 32'(seed[2:0]) + 32'h1;
		// rising, falling and both-edge counting of the same pulse train
		for (int md = 1; md < 4; md++) begin
			wr(`ECT_OFF_COUNT, 32'h0);
			wr(`ECT_OFF_CTRL, 32'(md * 4 + 1));
			P.drive(1'h0, m, 3);
			repeat (4) @(posedge aclk);
			rc(`ECT_OFF_COUNT, (md == 3) ? 2 * m : m);
		end
		wr(`ECT_OFF_CAP_CTL, 32'he);
		wr(`ECT_OFF_CTRL, 32'h1);
		m = 32'(seed[6:3]) + 32'h6;
		P.drive(1'h1, 1, m);
		wirq();
		rd(`ECT_OFF_CAP_VAL);
		chk(rv, m - 32'h1);
		rc(`ECT_OFF_INT_STAT, 32'h10);
		stop_test();
	end
endmodule // tb
